// ===== hdl/twowire_consts.vh
// constants for the two-wire byte master: register map, fields, timing
`ifndef TWOWIRE_CONSTS_VH
`define TWOWIRE_CONSTS_VH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_CONTROL_STATUS 16'hE678
`define IDX_DATA           16'hE679
`define IDX_BUS_CONTROL    16'hE67A

// ----------------------------------------------------------------
// control-status fields
// ----------------------------------------------------------------
`define CS_START      7
`define CS_STOP       6
`define CS_FINAL_READ 5
`define CS_KIND_HI    4
`define CS_KIND_LO    3
`define CS_BUS_ERROR  2
`define CS_ACK        1
`define CS_DONE       0

// ----------------------------------------------------------------
// bus-control fields and reset value
// ----------------------------------------------------------------
`define BC_STOP_IRQ_EN 1
`define BC_FAST_RATE   0
`define BC_RESET       8'h00

// ----------------------------------------------------------------
// timing: quarter bit period in ns, clock rate in MHz
// ----------------------------------------------------------------
`define CLK_MHZ        20
`define SLOW_QUARTER_NS 2500
`define FAST_QUARTER_NS 625

`endif

// ===== hdl/twowire_master.v
// two-wire byte master with an avalon-mm register slave
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
`include "twowire_consts.vh"

module twowire_master (
  input  wire        CLK,
  input  wire        RST,
  input  wire [17:0] ADDRESS,
  input  wire [3:0]  BYTEENABLE,
  input  wire        READ,
  input  wire        WRITE,
  input  wire [31:0] WRITEDATA,
  output reg  [31:0] READDATA,
  output wire        WAITREQUEST,
  input  wire [1:0]  BOOT_PROM_KIND,
  input  wire        EXT_IRQ_CLR,
  output reg         IRQ,
  input  wire        SCL_I,
  output wire        SCL_O,
  output wire        SCL_OE,
  input  wire        SDA_I,
  output wire        SDA_O,
  output wire        SDA_OE
);

  // ----------------------------------------------------------------
  // constants
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_BITS  = 2'h2;
  localparam [1:0] ST_STOP  = 2'h3;

  // least quarter period, so the bus never runs faster than named
  localparam integer SLOW_Q = (`SLOW_QUARTER_NS * `CLK_MHZ + 999) / 1000;
  localparam integer FAST_Q = (`FAST_QUARTER_NS * `CLK_MHZ + 999) / 1000;
  localparam [6:0]   SLOW_RELOAD = SLOW_Q[6:0] - 7'h01;
  localparam [6:0]   FAST_RELOAD = FAST_Q[6:0] - 7'h01;

  function hit;
    input [17:0] addr;
    input [15:0] idx;
    begin
      hit = (addr[17:2] == idx);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg        ack_cycle_reg;
  reg        start_reg;
  reg        stop_reg;
  reg        stop_d_reg;
  reg        final_read_reg;
  reg        bus_error_reg;
  reg        ack_reg;
  reg        done_reg;
  reg [1:0]  kind_reg;
  reg        kind_taken_reg;
  reg        stop_ie_reg;
  reg        fast_reg;
  reg [7:0]  data_reg;
  reg [7:0]  shift_reg;
  reg        sample_reg;
  reg        xfer_read_reg;
  reg [1:0]  state_reg;
  reg [1:0]  phase_reg;
  reg [3:0]  bit_reg;
  reg        hold_reg;
  reg [6:0]  qcnt_reg;
  reg        scl_low_reg;
  reg        sda_low_reg;
  reg        scl_m_reg;
  reg        scl_s_reg;
  reg        sda_m_reg;
  reg        sda_s_reg;

  wire       acc     = (READ | WRITE) & ~ack_cycle_reg;
  wire       wr      = WRITE & BYTEENABLE[0];
  wire       hit_cs  = hit(ADDRESS, `IDX_CONTROL_STATUS);
  wire       hit_dat = hit(ADDRESS, `IDX_DATA);
  wire       hit_bc  = hit(ADDRESS, `IDX_BUS_CONTROL);
  wire       tick    = (qcnt_reg == 7'h00);
  wire       busy    = ~scl_s_reg | ~sda_s_reg;
  wire [7:0] cs_view = {start_reg, stop_reg, final_read_reg, kind_reg,
                        bus_error_reg, ack_reg, done_reg};

  // one wait cycle per access; effects happen on the first edge
  assign WAITREQUEST = (READ | WRITE) & ~ack_cycle_reg;

  // open-drain: only ever pull low
  // sole master on the lines
  // drive-low only
  assign SCL_O  = 1'b0;
  assign SDA_O  = 1'b0;
  assign SCL_OE = scl_low_reg;
  assign SDA_OE = sda_low_reg;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      scl_m_reg <= SCL_I;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= SDA_I;
      sda_s_reg <= sda_m_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers and byte engine
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (RST) begin
      ack_cycle_reg  <= 1'b0;
      READDATA       <= 32'h00000000;
      start_reg      <= 1'b0;
      stop_reg       <= 1'b0;
      stop_d_reg     <= 1'b0;
      final_read_reg <= 1'b0;
      bus_error_reg  <= 1'b0;
      ack_reg        <= 1'b0;
      done_reg       <= 1'b0;
      kind_reg       <= 2'h0;
      kind_taken_reg <= 1'b0;
      stop_ie_reg    <= 1'b0;
      fast_reg       <= 1'b0;
      data_reg       <= 8'h00;
      shift_reg      <= 8'h00;
      sample_reg     <= 1'b1;
      xfer_read_reg  <= 1'b0;
      state_reg      <= ST_IDLE;
      phase_reg      <= 2'h0;
      bit_reg        <= 4'h0;
      hold_reg       <= 1'b0;
      qcnt_reg       <= 7'h00;
      scl_low_reg    <= 1'b0;
      sda_low_reg    <= 1'b0;
      IRQ            <= 1'b0;
    end else begin
      ack_cycle_reg <= acc;
      stop_d_reg    <= stop_reg;

      // boot loader result caught once, after reset release
      // capture prom kind
      if (!kind_taken_reg) begin
        kind_reg       <= BOOT_PROM_KIND;
        kind_taken_reg <= 1'b1;
      end

      if (tick) begin
        qcnt_reg <= fast_reg ? FAST_RELOAD : SLOW_RELOAD;
      end else begin
        qcnt_reg <= qcnt_reg - 7'h01;
      end

      if ((acc & (hit_cs | hit_dat)) | EXT_IRQ_CLR) begin
        IRQ <= 1'b0;
      end

      if (acc) begin
        READDATA <= 32'h00000000;
        if (hit_cs) begin
          READDATA[7:0] <= cs_view;
        end else if (hit_dat) begin
          READDATA[7:0] <= data_reg;
        end else if (hit_bc) begin
          READDATA[1:0] <= {stop_ie_reg, fast_reg};
        end
        if (wr & hit_cs) begin
          start_reg      <= WRITEDATA[`CS_START];
          // stop may be set at any time
          stop_reg       <= WRITEDATA[`CS_STOP];
          final_read_reg <= WRITEDATA[`CS_FINAL_READ];
        end
        if (wr & hit_bc) begin
          stop_ie_reg <= WRITEDATA[`BC_STOP_IRQ_EN];
          fast_reg    <= WRITEDATA[`BC_FAST_RATE];
        end
        if (hit_dat) begin
          done_reg <= 1'b0;
          if (wr) begin
            data_reg <= WRITEDATA[7:0];
          end
          if (state_reg == ST_IDLE) begin
            if (bus_error_reg & busy) begin
              state_reg <= ST_IDLE;
            end else if (WRITE) begin
              shift_reg     <= WRITEDATA[7:0];
              xfer_read_reg <= 1'b0;
              phase_reg     <= 2'h0;
              bit_reg       <= 4'h0;
              state_reg     <= start_reg ? ST_START : ST_BITS;
            end else begin
              xfer_read_reg <= 1'b1;
              phase_reg     <= 2'h0;
              bit_reg       <= 4'h0;
              state_reg     <= ST_BITS;
            end
          end
        end
      end

      case (state_reg)
        ST_IDLE: begin
          // stop asked for after the byte already ended
          if (stop_reg & ~acc & tick) begin
            if (hold_reg) begin
              phase_reg <= 2'h0;
              state_reg <= ST_STOP;
            end else begin
              stop_reg <= 1'b0;
            end
          end
        end
        ST_START: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin
                scl_low_reg <= 1'b1;
                sda_low_reg <= 1'b0;
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
              end
              2'h2: begin
                sda_low_reg <= 1'b1;
              end
              default: begin
                scl_low_reg <= 1'b1;
                hold_reg    <= 1'b1;
                state_reg   <= ST_BITS;
              end
            endcase
          end
        end
        ST_BITS: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin
                scl_low_reg <= 1'b1;
                if (bit_reg == 4'h8) begin
                  sda_low_reg <= xfer_read_reg & ~final_read_reg;
                end else begin
                  sda_low_reg <= ~xfer_read_reg & ~shift_reg[7];
                end
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
              end
              2'h2: begin
                sample_reg <= sda_s_reg;
                // released line read low: someone else drives it
                // contention aborts the byte
                if (~xfer_read_reg & (bit_reg != 4'h8) & shift_reg[7] & ~sda_s_reg) begin
                  scl_low_reg   <= 1'b0;
                  sda_low_reg   <= 1'b0;
                  hold_reg      <= 1'b0;
                  bus_error_reg <= 1'b1;
                  done_reg      <= 1'b1;
                  IRQ           <= 1'b1;
                  start_reg     <= 1'b0;
                  state_reg     <= ST_IDLE;
                end
              end
              default: begin
                scl_low_reg <= 1'b1;
                hold_reg    <= 1'b1;
                if (bit_reg == 4'h8) begin
                  if (!xfer_read_reg) begin
                    ack_reg <= ~sample_reg;
                  end else begin
                    data_reg <= shift_reg;
                  end
                  done_reg       <= 1'b1;
                  IRQ            <= 1'b1;
                  bus_error_reg  <= 1'b0;
                  start_reg      <= 1'b0;
                  final_read_reg <= 1'b0;
                  sda_low_reg    <= 1'b0;
                  state_reg      <= stop_reg ? ST_STOP : ST_IDLE;
                end else begin
                  shift_reg <= {shift_reg[6:0], sample_reg};
                  bit_reg   <= bit_reg + 4'h1;
                end
              end
            endcase
          end
        end
        ST_STOP: begin
          if (tick) begin
            phase_reg <= phase_reg + 2'h1;
            case (phase_reg)
              2'h0: begin
                scl_low_reg <= 1'b1;
                sda_low_reg <= 1'b1;
              end
              2'h1: begin
                scl_low_reg <= 1'b0;
              end
              2'h2: begin
                sda_low_reg <= 1'b0;
              end
              default: begin
                // stop flag clears when stop is done
                stop_reg  <= 1'b0;
                hold_reg  <= 1'b0;
                state_reg <= ST_IDLE;
              end
            endcase
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase

      if (stop_d_reg & ~stop_reg & stop_ie_reg) begin
        IRQ <= 1'b1;
      end
    end
  end

endmodule

// ===== testbench/i2c_master_byte_controller_tb_top.sv
// self-checking bench for the two-wire byte master
`timescale 1ns/1ps
module i2c_master_byte_controller_tb_top;
  localparam [17:0] A_CS = 18'h399E0;
  localparam [17:0] A_DT = 18'h399E4;
  localparam [17:0] A_BC = 18'h399E8;
  reg         clk;
  reg         rst;
  reg         rd;
  reg         wr;
  reg         clr;
  reg         jam;
  reg         s_ack;
  reg         s_rd;
  reg  [7:0]  s_tx;
  reg  [17:0] adr;
  reg  [31:0] wd;
  reg  [1:0]  kind;
  reg  [31:0] lf;
  reg  [7:0]  v;
  integer     n_mismatch;
  integer     cmp_count;
  logic [7:0] q[$];
  wire [31:0] rdat;
  wire        wait_req;
  wire        irq;
  wire        scl_oe;
  wire        sda_oe;
  wire        pull;
  wire [7:0]  rx;
  wire        scl = ~scl_oe;
  wire        sda = ~(sda_oe | pull | jam);
  twowire_master u_twowire_master (
    .CLK(clk), .RST(rst), .ADDRESS(adr), .BYTEENABLE(4'h1), .READ(rd), .WRITE(wr),
    .WRITEDATA(wd), .READDATA(rdat), .WAITREQUEST(wait_req), .BOOT_PROM_KIND(kind),
    .EXT_IRQ_CLR(clr), .IRQ(irq), .SCL_I(scl), .SCL_O(), .SCL_OE(scl_oe),
    .SDA_I(sda), .SDA_O(), .SDA_OE(sda_oe)
  );
  twowire_slave_model u_twowire_slave_model (
    .scl(scl), .sda(sda), .ack_en(s_ack), .rd_mode(s_rd), .tx(s_tx), .pull(pull), .rx(rx)
  );
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function [31:0] nxt(input [31:0] x);
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task bus(input w, input [17:0] a, input [7:0] d);
    integer n;
    begin
      n = 0;
      @(posedge clk);
      adr <= a;
      wd <= {24'h000000, d};
      rd <= ~w;
      wr <= w;
      // look at waitrequest mid-cycle, act on the following rising edge
      @(negedge clk);
      while (wait_req !== 1'b0 && n < 16) begin
        @(negedge clk);
        n = n + 1;
      end
      chk({7'h00, wait_req}, 8'h00);
      @(posedge clk);
      v = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task wirq;
    integer n;
    begin
      n = 0;
      // bounded wait: a cancelled restart never completes
      // timeout on completion
      while (irq !== 1'b1 && n < 5000) begin
        @(negedge clk);
        n = n + 1;
      end
      chk({7'h00, irq}, 8'h01);
      @(posedge clk);
    end
  endtask
  task conclude;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude;
  end
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    lf = 32'h4B30B8D2;
    kind = lf[4:3];
    {rst, rd, wr, clr, jam, s_ack, s_rd} = 7'h40;
    s_tx = 8'h00;
    adr = 18'h00000;
    wd = 32'h00000000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    bus(0, A_CS, 8'h00);
    chk(v, {3'b000, kind, 3'b000});
    bus(0, A_BC, 8'h00);
    chk(v, 8'h00);
    bus(1, 18'h399EC, 8'hFF);
    bus(0, 18'h399EC, 8'h00);
    chk(v, 8'h00);
    $display("test registers done");
    s_ack <= 1'b1;
    bus(1, A_CS, 8'h80);
    lf = nxt(lf);
    q.push_back(lf[7:0]);
    bus(1, A_DT, lf[7:0]);
    wirq;
    chk(rx, q.pop_front());
    bus(0, A_CS, 8'h00);
    chk(v, {3'b000, kind, 3'b011});
    chk({7'h00, irq}, 8'h00);
    s_ack <= 1'b0;
    lf = nxt(lf);
    q.push_back(lf[7:0]);
    bus(1, A_DT, lf[7:0]);
    wirq;
    chk(rx, q.pop_front());
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    bus(0, A_CS, 8'h00);
    chk(v, {3'b000, kind, 3'b001});
    $display("test writes done");
    bus(1, A_BC, 8'h03);
    lf = nxt(lf);
    s_tx <= lf[7:0];
    s_rd <= 1'b1;
    bus(0, A_DT, 8'h00);
    bus(0, A_CS, 8'h00);
    chk(v & 8'h01, 8'h00);
    bus(1, A_CS, 8'h60);
    wirq;
    chk(rx, 8'h01);
    bus(0, A_CS, 8'h00);
    chk(v & 8'h25, 8'h01);
    wirq;
    bus(0, A_CS, 8'h00);
    chk(v & 8'h40, 8'h00);
    bus(0, A_DT, 8'h00);
    chk(v, s_tx);
    s_rd <= 1'b0;
    wirq;
    chk({7'h00, scl_oe}, 8'h01);
    bus(0, A_CS, 8'h00);
    $display("test final read done");
    bus(1, A_CS, 8'h80);
    jam <= 1'b1;
    bus(1, A_DT, 8'hFF);
    wirq;
    bus(0, A_CS, 8'h00);
    chk(v & 8'h05, 8'h05);
    chk({6'h00, scl_oe, sda_oe}, 8'h00);
    bus(1, A_DT, 8'h55);
    repeat (600) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    bus(0, A_CS, 8'h00);
    chk(v & 8'h05, 8'h04);
    jam <= 1'b0;
    $display("test contention done");
    conclude;
  end
endmodule

// ===== testbench/twowire_master_assertions.sv
// port-level checks for the two-wire byte master
`timescale 1ns/1ps
module twowire_master_assertions (
  input wire        CLK,
  input wire        RST,
  input wire [17:0] ADDRESS,
  input wire [3:0]  BYTEENABLE,
  input wire        READ,
  input wire        WRITE,
  input wire [31:0] WRITEDATA,
  input wire [31:0] READDATA,
  input wire        WAITREQUEST,
  input wire [1:0]  BOOT_PROM_KIND,
  input wire        EXT_IRQ_CLR,
  input wire        IRQ,
  input wire        SCL_I,
  input wire        SCL_O,
  input wire        SCL_OE,
  input wire        SDA_I,
  input wire        SDA_O,
  input wire        SDA_OE
);
  localparam [17:0] A_CS = 18'h399E0;
  localparam [17:0] A_DT = 18'h399E4;
  localparam [17:0] A_BC = 18'h399E8;
  wire        taken  = (READ | WRITE) & WAITREQUEST;
  wire        hit    = (ADDRESS == A_CS) | (ADDRESS == A_DT);
  wire        answer = READ & ~WAITREQUEST;
  reg         fast_reg;
  reg         scl_q_reg;
  reg  [15:0] run_reg;
  // run length of the clock drive level; saturated so idle stretches never look short
  always @(posedge CLK) begin
    if (RST) begin
      fast_reg <= 1'b0;
      scl_q_reg <= 1'b0;
      run_reg <= 16'hFFFF;
    end else begin
      scl_q_reg <= SCL_OE;
      if (taken && WRITE && ADDRESS == A_BC && BYTEENABLE[0])
        fast_reg <= WRITEDATA[0];
      if (SCL_OE != scl_q_reg)
        run_reg <= 16'h0001;
      else if (run_reg != 16'hFFFF)
        run_reg <= run_reg + 16'h0001;
    end
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RST);
  property p_wait_answer; taken |=> !WAITREQUEST; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("access not answered");
  property p_wait_cause; WAITREQUEST |-> (READ || WRITE); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait without request");
  property p_read_upper; answer |-> READDATA[31:8] == 24'h000000; endproperty
  a_read_upper: assert property (p_read_upper) else $error("upper read lanes not zero");
  property p_unmapped; answer && !hit && ADDRESS != A_BC |-> READDATA == 32'h00000000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_kind; answer && ADDRESS == A_CS |-> READDATA[4:3] == BOOT_PROM_KIND; endproperty
  a_kind: assert property (p_kind) else $error("boot kind field wrong");
  property p_irq_clear; (taken && hit) || EXT_IRQ_CLR |=> !IRQ; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
  property p_irq_hold; IRQ && !EXT_IRQ_CLR && !(taken && hit) |=> IRQ; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
  property p_reset_idle; $fell(RST) |-> !SCL_OE && !SDA_OE && !IRQ; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("lines or irq active from reset");
  property p_open_drain; !SCL_O && !SDA_O; endproperty
  a_open_drain: assert property (p_open_drain) else $error("line output not low");
  property p_high_phase; $rose(SCL_OE) |-> run_reg >= (fast_reg ? 16'h001A : 16'h0064); endproperty
  a_high_phase: assert property (p_high_phase) else $error("clock high phase too short");
  property p_low_phase; $fell(SCL_OE) |-> run_reg >= (fast_reg ? 16'h000D : 16'h0032); endproperty
  a_low_phase: assert property (p_low_phase) else $error("clock low phase too short");
endmodule

bind twowire_master twowire_master_assertions u_twowire_master_assertions (
  .CLK(CLK), .RST(RST), .ADDRESS(ADDRESS), .BYTEENABLE(BYTEENABLE), .READ(READ), .WRITE(WRITE),
  .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST), .BOOT_PROM_KIND(BOOT_PROM_KIND),
  .EXT_IRQ_CLR(EXT_IRQ_CLR), .IRQ(IRQ), .SCL_I(SCL_I), .SCL_O(SCL_O), .SCL_OE(SCL_OE),
  .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE)
);

// ===== testbench/twowire_slave_model.sv
// behavioural bus peripheral: acks writes, serves read bytes
`timescale 1ns/1ps
module twowire_slave_model (
  input  wire       scl,
  input  wire       sda,
  input  wire       ack_en,
  input  wire       rd_mode,
  input  wire [7:0] tx,
  output wire       pull,
  output reg  [7:0] rx
);
  integer   cnt = 0;
  integer   pos = 0;
  reg       act = 1'b0;
  reg [7:0] sh  = 8'h00;
  always @(negedge sda) begin
    if (scl) begin
      act = 1'b1;
      cnt = 0;
      pos = 0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      act = 1'b0;
      cnt = 0;
    end
  end
  // in read mode rx keeps the master's ack-slot level instead of data
  always @(posedge scl) begin
    if (cnt < 8)
      sh = {sh[6:0], sda};
    if (cnt == 7)
      rx = sh;
    if (cnt == 8 && rd_mode)
      rx = {7'h00, sda};
    if (cnt == 8 && rd_mode && sda)
      act = 1'b0;
    cnt = cnt + 1;
  end
  // pull's bit position advances only on the falling clock edge; rx updates on the rising edge
  always @(negedge scl) begin
    if (cnt == 9)
      cnt = 0;
    pos = cnt;
  end
  assign pull = act & (rd_mode ? (pos < 8 && !tx[7 - pos]) : (pos == 8 && ack_en));
endmodule
